// ===== verilog/trip_pkg.sv
// Purpose: Shared constants for the drive protection and trip logic.
// Assumes: 100 MHz control clock, 32-bit classic Wishbone register port.
// Notes: Byte offsets are word aligned; unmapped reads return zero.
package trip_pkg;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_IN_FUNC = 8'h04;
    localparam logic [7:0] OFS_OUT_FUNC = 8'h08;
    localparam logic [7:0] OFS_QUAL_TIME = 8'h0C;
    localparam logic [7:0] OFS_V_MIN = 8'h10;
    localparam logic [7:0] OFS_I_MIN = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
    // CTRL and other register field positions, and the function field width.
    localparam int CTRL_PHASE_EN = 0;
    localparam int CTRL_EXT_IO = 1;
    localparam int CTRL_DET_LO = 2;
    localparam int CTRL_ACT_LO = 4;
    localparam int CTRL_CLEAR = 6;
    localparam int CTRL_COMBINED = 7;
    localparam int FUNC_W = 5;
    localparam int OUT2_LO = 8;
    localparam int AUX_MIN_LO = 16;
    // Reset values.
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [4:0] IN1_FUNC_RST = 5'h00;
    localparam logic [4:0] IN2_FUNC_RST = 5'h00;
    localparam logic [4:0] IN3_FUNC_RST = 5'h00;
    localparam logic [4:0] IN4_FUNC_RST = 5'h03;
    localparam logic [4:0] IN5_FUNC_RST = 5'h04;
    localparam logic [4:0] OUT_FUNC_RST = 5'h11;
    localparam logic [10:0] QUAL_TIME_RST = 11'h00A;
    localparam logic [10:0] QUAL_TIME_MIN = 11'h001;
    localparam logic [10:0] QUAL_TIME_MAX = 11'h4B0;
    localparam logic [11:0] MIN_POINT_RST = 12'h000;
    // Function codes and limits.
    localparam logic [4:0] IN_FUNC_MAX = 5'h1B;
    localparam logic [4:0] FUNC_EXT_NO = 5'h12;
    localparam logic [4:0] FUNC_EXT_NC = 5'h13;
    localparam logic [4:0] OUT_FUNC_MAX = 5'h13;
    localparam logic [4:0] OUT_OVERLOAD = 5'h06;
    localparam logic [4:0] OUT_CMD_LOSS = 5'h0B;
    localparam logic [1:0] DET_OFF = 2'h0;
    localparam logic [1:0] DET_HALF = 2'h1;
    localparam logic [1:0] ACT_CONTINUE = 2'h0;
    localparam logic [1:0] ACT_COAST = 2'h1;
    localparam logic [1:0] ACT_DECEL = 2'h2;
    // Trip cause bit positions, shared by status and interrupt registers.
    localparam int CAUSE_PHASE = 0;
    localparam int CAUSE_EXT_NO = 1;
    localparam int CAUSE_EXT_NC = 2;
    localparam int CAUSE_OVERLOAD = 3;
    localparam int CAUSE_CMD_LOSS = 4;
    localparam int CAUSE_W = 5;
    // Timing.
    localparam int CLK_PERIOD_NS = 10;
    localparam int QUAL_TICK_MS = 100;
    localparam int QUAL_TICK_CYC = QUAL_TICK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int OVL_TICK_MS = 1;
    localparam int OVL_TICK_CYC = OVL_TICK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int OVL_BUDGET = 6000;
endpackage

// ===== verilog/drive_protection_trip_logic.sv
// Purpose: Protection and trip logic of a motor drive with a Wishbone register port.
// Assumes: All inputs synchronous to clk_i; dig_in_i high means contact closed to common.
// Notes: Trip causes latch until a clear is written and the cause has gone; a closed-contact trip also needs its input to keep that function.
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module drive_protection_trip_logic #(
    parameter int QUAL_TICK = trip_pkg::QUAL_TICK_CYC,
    parameter int OVL_TICK = trip_pkg::OVL_TICK_CYC
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [2:0] phase_open_i,
    input wire logic [4:0] dig_in_i,
    input wire logic [7:0] overload_excess_i,
    input wire logic [11:0] voltage_analog_input_i,
    input wire logic [11:0] aux_voltage_input_i,
    input wire logic [11:0] current_analog_input_i,
    output logic output_block_o,
    output logic decel_stop_o,
    output logic relay_o,
    output logic output2_o,
    output logic irq_o
);
    logic [7:0] ctrl_r;
    logic [4:0] in_func_r [5];
    logic [4:0] relay_func_r;
    logic [4:0] out2_func_r;
    logic [10:0] qual_time_r;
    logic [11:0] v_min_r;
    logic [11:0] aux_min_r;
    logic [11:0] i_min_r;
    logic [4:0] cause_r;
    logic [4:0] irq_stat_r;
    logic [4:0] irq_mask_r;
    logic [2:0] nc_src_r;
    logic [31:0] qual_tick_r;
    logic [10:0] qual_cnt_r;
    logic cmd_loss_det_r;
    logic [31:0] ovl_tick_r;
    logic [19:0] ovl_acc_r;
    logic ack_r;
    logic [31:0] rdata_r;

    wire req = wb_cyc_i && wb_stb_i && !ack_r;
    wire wr = req && wb_we_i && (wb_sel_i == 4'hF);
    wire wr_ctrl = wr && (wb_adr_i == trip_pkg::OFS_CTRL);
    wire wr_in = wr && (wb_adr_i == trip_pkg::OFS_IN_FUNC);
    wire wr_out = wr && (wb_adr_i == trip_pkg::OFS_OUT_FUNC);
    wire wr_qual = wr && (wb_adr_i == trip_pkg::OFS_QUAL_TIME);
    wire wr_vmin = wr && (wb_adr_i == trip_pkg::OFS_V_MIN);
    wire wr_imin = wr && (wb_adr_i == trip_pkg::OFS_I_MIN);
    wire wr_istat = wr && (wb_adr_i == trip_pkg::OFS_IRQ_STAT);
    wire wr_imask = wr && (wb_adr_i == trip_pkg::OFS_IRQ_MASK);
    wire clear_req = wr_ctrl && wb_dat_i[trip_pkg::CTRL_CLEAR];

    wire phase_en = ctrl_r[trip_pkg::CTRL_PHASE_EN];
    wire ext_io = ctrl_r[trip_pkg::CTRL_EXT_IO];
    wire [1:0] det_mode = ctrl_r[trip_pkg::CTRL_DET_LO +: 2];
    wire [1:0] loss_act = ctrl_r[trip_pkg::CTRL_ACT_LO +: 2];
    wire combined = ctrl_r[trip_pkg::CTRL_COMBINED];

    // Per-input external trip detection.
    logic [4:0] in_live;
    logic [4:0] no_hit;
    logic [4:0] nc_hit;
    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_in
            assign in_live[g] = (g < 3) || ext_io;
            assign no_hit[g] = in_live[g] && (in_func_r[g] == trip_pkg::FUNC_EXT_NO)
                && dig_in_i[g];
            assign nc_hit[g] = in_live[g] && (in_func_r[g] == trip_pkg::FUNC_EXT_NC)
                && !dig_in_i[g];
        end
    endgenerate

    logic [2:0] nc_first;
    always_comb begin
        nc_first = 3'h0;
        for (int k = 4; k >= 0; k--) begin
            if (nc_hit[k]) begin
                nc_first = 3'(k);
            end
        end
    end

    // The closed-contact trip may only clear once its own contact is closed again
    // and the input still carries that function.
    wire nc_clear_ok = dig_in_i[nc_src_r] && (in_func_r[nc_src_r] == trip_pkg::FUNC_EXT_NC);

    // Command loss condition.
    wire [11:0] v_thr = (det_mode == trip_pkg::DET_HALF) ? (v_min_r >> 1) : v_min_r;
    wire [11:0] a_thr = (det_mode == trip_pkg::DET_HALF) ? (aux_min_r >> 1) : aux_min_r;
    wire [11:0] i_thr = (det_mode == trip_pkg::DET_HALF) ? (i_min_r >> 1) : i_min_r;
    wire loss_single = voltage_analog_input_i < v_thr;
    wire loss_comb = (aux_voltage_input_i < a_thr) || (current_analog_input_i < i_thr);
    wire loss_cond = (det_mode != trip_pkg::DET_OFF) && (combined ? loss_comb : loss_single);
    wire qual_tick_end = qual_tick_r == 32'(QUAL_TICK - 1);
    wire loss_qualified = loss_cond && (qual_cnt_r >= qual_time_r);

    // Overload accumulator: larger excess fills the budget sooner.
    wire ovl_tick_end = ovl_tick_r == 32'(OVL_TICK - 1);
    wire [19:0] ovl_sum = ovl_acc_r + 20'(overload_excess_i);
    wire ovl_trip = ovl_acc_r >= 20'(trip_pkg::OVL_BUDGET);

    // Trip causes raised this cycle.
    logic [4:0] cause_set;
    assign cause_set[trip_pkg::CAUSE_PHASE] = phase_en && (phase_open_i != 3'h0);
    assign cause_set[trip_pkg::CAUSE_EXT_NO] = |no_hit;
    assign cause_set[trip_pkg::CAUSE_EXT_NC] = |nc_hit;
    assign cause_set[trip_pkg::CAUSE_OVERLOAD] = ovl_trip;
    assign cause_set[trip_pkg::CAUSE_CMD_LOSS] = cmd_loss_det_r
        && (loss_act != trip_pkg::ACT_CONTINUE);

    logic [4:0] cause_clr;
    assign cause_clr[trip_pkg::CAUSE_PHASE] = clear_req;
    assign cause_clr[trip_pkg::CAUSE_EXT_NO] = clear_req;
    assign cause_clr[trip_pkg::CAUSE_EXT_NC] = clear_req && nc_clear_ok;
    assign cause_clr[trip_pkg::CAUSE_OVERLOAD] = clear_req;
    assign cause_clr[trip_pkg::CAUSE_CMD_LOSS] = clear_req;
    // Set wins over clear, so a cause still present survives the clear.
    wire [4:0] cause_nxt = cause_set | (cause_r & ~cause_clr);
    wire [4:0] cause_rise = cause_nxt & ~cause_r;

    wire cmd_trip = cause_nxt[trip_pkg::CAUSE_CMD_LOSS];
    wire block_nxt = (|cause_nxt[trip_pkg::CAUSE_OVERLOAD:trip_pkg::CAUSE_PHASE])
        || (cmd_trip && (loss_act == trip_pkg::ACT_COAST))
        || (cmd_trip && output_block_o && !clear_req);
    wire decel_nxt = cmd_trip && (loss_act == trip_pkg::ACT_DECEL);

    wire ovl_flag = cause_nxt[trip_pkg::CAUSE_OVERLOAD];
    wire relay_nxt = ((relay_func_r == trip_pkg::OUT_OVERLOAD) && ovl_flag)
        || ((relay_func_r == trip_pkg::OUT_CMD_LOSS) && loss_qualified);
    wire out2_nxt = ((out2_func_r == trip_pkg::OUT_OVERLOAD) && ovl_flag)
        || ((out2_func_r == trip_pkg::OUT_CMD_LOSS) && loss_qualified);

    wire [4:0] istat_nxt = cause_rise | (irq_stat_r & ~(wr_istat ? wb_dat_i[4:0] : 5'h00));

    // Written values outside the legal range are ignored field by field.
    wire [4:0] wf [5];
    generate
        for (g = 0; g < 5; g++) begin : g_wf
            assign wf[g] = wb_dat_i[g*trip_pkg::FUNC_W +: trip_pkg::FUNC_W];
        end
    endgenerate
    wire [4:0] w_relay = wb_dat_i[4:0];
    wire [4:0] w_out2 = wb_dat_i[trip_pkg::OUT2_LO +: 5];
    wire [10:0] w_qual = wb_dat_i[10:0];
    wire qual_ok = (w_qual >= trip_pkg::QUAL_TIME_MIN) && (w_qual <= trip_pkg::QUAL_TIME_MAX);

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (wb_adr_i)
            trip_pkg::OFS_CTRL: rd_mux = {24'h000000, 1'b0, ctrl_r[6:0] & 7'h3F}
                | {24'h000000, ctrl_r[7], 7'h00};
            trip_pkg::OFS_IN_FUNC: rd_mux = {7'h00, in_func_r[4], in_func_r[3],
                in_func_r[2], in_func_r[1], in_func_r[0]};
            trip_pkg::OFS_OUT_FUNC: rd_mux = {19'h00000, out2_func_r, 3'h0, relay_func_r};
            trip_pkg::OFS_QUAL_TIME: rd_mux = {21'h000000, qual_time_r};
            trip_pkg::OFS_V_MIN: rd_mux = {4'h0, aux_min_r, 4'h0, v_min_r};
            trip_pkg::OFS_I_MIN: rd_mux = {20'h00000, i_min_r};
            trip_pkg::OFS_STATUS: rd_mux = {16'h0000, 5'h00, nc_src_r, 3'h0, cmd_loss_det_r,
                decel_stop_o, output_block_o, 1'b0, 1'b0} << 0 | {27'h0000000, cause_r};
            trip_pkg::OFS_IRQ_STAT: rd_mux = {27'h0000000, irq_stat_r};
            trip_pkg::OFS_IRQ_MASK: rd_mux = {27'h0000000, irq_mask_r};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Bus answer, one cycle after the request is seen.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= req;
            rdata_r <= req ? rd_mux : 32'h0000_0000;
        end
    end
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;

    // Configuration registers.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_r <= trip_pkg::CTRL_RST;
            relay_func_r <= trip_pkg::OUT_FUNC_RST;
            out2_func_r <= trip_pkg::OUT_FUNC_RST;
            qual_time_r <= trip_pkg::QUAL_TIME_RST;
            v_min_r <= trip_pkg::MIN_POINT_RST;
            aux_min_r <= trip_pkg::MIN_POINT_RST;
            i_min_r <= trip_pkg::MIN_POINT_RST;
            irq_mask_r <= 5'h00;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= wb_dat_i[7:0] & 8'hBF;
            end
            if (wr_out && (w_relay <= trip_pkg::OUT_FUNC_MAX)) begin
                relay_func_r <= w_relay;
            end
            if (wr_out && (w_out2 <= trip_pkg::OUT_FUNC_MAX)) begin
                out2_func_r <= w_out2;
            end
            if (wr_qual && qual_ok) begin
                qual_time_r <= w_qual;
            end
            if (wr_vmin) begin
                v_min_r <= wb_dat_i[11:0];
                aux_min_r <= wb_dat_i[trip_pkg::AUX_MIN_LO +: 12];
            end
            if (wr_imin) begin
                i_min_r <= wb_dat_i[11:0];
            end
            if (wr_imask) begin
                irq_mask_r <= wb_dat_i[4:0];
            end
        end
    end

    // Input function selectors.
    localparam logic [4:0] IN_RST [5] = '{trip_pkg::IN1_FUNC_RST, trip_pkg::IN2_FUNC_RST,
        trip_pkg::IN3_FUNC_RST, trip_pkg::IN4_FUNC_RST, trip_pkg::IN5_FUNC_RST};
    generate
        for (g = 0; g < 5; g++) begin : g_func
            always_ff @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    in_func_r[g] <= IN_RST[g];
                end else if (wr_in && (wf[g] <= trip_pkg::IN_FUNC_MAX)) begin
                    in_func_r[g] <= wf[g];
                end
            end
        end
    endgenerate

    // Loss qualification timer in tenths of a second.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            qual_tick_r <= 32'h0000_0000;
            qual_cnt_r <= 11'h000;
            cmd_loss_det_r <= 1'b0;
        end else begin
            if (!loss_cond) begin
                qual_tick_r <= 32'h0000_0000;
                qual_cnt_r <= 11'h000;
            end else if (qual_tick_end) begin
                qual_tick_r <= 32'h0000_0000;
                if (qual_cnt_r < qual_time_r) begin
                    qual_cnt_r <= qual_cnt_r + 11'h001;
                end
            end else begin
                qual_tick_r <= qual_tick_r + 32'h0000_0001;
            end
            cmd_loss_det_r <= loss_qualified;
        end
    end

    // Overload accumulator.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ovl_tick_r <= 32'h0000_0000;
            ovl_acc_r <= 20'h00000;
        end else begin
            ovl_tick_r <= ovl_tick_end ? 32'h0000_0000 : ovl_tick_r + 32'h0000_0001;
            if (overload_excess_i == 8'h00) begin
                ovl_acc_r <= 20'h00000;
            end else if (ovl_tick_end && !ovl_trip) begin
                ovl_acc_r <= ovl_sum;
            end
        end
    end

    // Trip latches, interrupts and outputs.
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cause_r <= 5'h00;
            nc_src_r <= 3'h0;
            irq_stat_r <= 5'h00;
            output_block_o <= 1'b0;
            decel_stop_o <= 1'b0;
            relay_o <= 1'b0;
            output2_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            cause_r <= cause_nxt;
            if (cause_set[trip_pkg::CAUSE_EXT_NC] && !cause_r[trip_pkg::CAUSE_EXT_NC]) begin
                nc_src_r <= nc_first;
            end
            irq_stat_r <= istat_nxt;
            output_block_o <= block_nxt;
            decel_stop_o <= decel_nxt;
            relay_o <= relay_nxt;
            output2_o <= out2_nxt;
            irq_o <= |(istat_nxt & irq_mask_r);
        end
    end

    sequence s_open_phase;
        phase_en && (phase_open_i != 3'h0);
    endsequence
    chk_phase_block: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_open_phase |=> output_block_o)
        else $error("Open phase did not block output.");
    chk_phase_reset: assert property (@(posedge clk_i)
        $fell(sys_rst_i) |-> !phase_en)
        else $error("Phase loss selection not zero after reset.");
    chk_in_range: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        in_func_r[3] <= trip_pkg::IN_FUNC_MAX && in_func_r[4] <= trip_pkg::IN_FUNC_MAX)
        else $error("Input function outside range.");
    chk_no_trip: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (in_func_r[0] == trip_pkg::FUNC_EXT_NO && dig_in_i[0]) |=> output_block_o)
        else $error("Normally open trip not blocking.");
    chk_nc_trip: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (in_func_r[1] == trip_pkg::FUNC_EXT_NC && !dig_in_i[1]) |=> output_block_o)
        else $error("Normally closed trip not blocking.");
    chk_nc_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (cause_r[trip_pkg::CAUSE_EXT_NC] && !dig_in_i[nc_src_r])
        |=> cause_r[trip_pkg::CAUSE_EXT_NC])
        else $error("Closed-contact trip cleared while contact open.");
    chk_basic_io: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !ext_io |-> !no_hit[3] && !no_hit[4] && !nc_hit[3] && !nc_hit[4])
        else $error("Extended input active on basic variant.");
    chk_relay_ovl: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (relay_func_r == trip_pkg::OUT_OVERLOAD && cause_r[trip_pkg::CAUSE_OVERLOAD]
        && !clear_req) |=> relay_o)
        else $error("Relay missed overload trip.");
    chk_relay_loss: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (relay_func_r == trip_pkg::OUT_CMD_LOSS && $rose(relay_o)) |-> $past(loss_qualified))
        else $error("Relay set without command loss.");
    chk_qual_wait: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(cmd_loss_det_r) |-> $past(qual_cnt_r) >= $past(qual_time_r))
        else $error("Command loss acted before qualification time.");
    chk_latch_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (output_block_o && !clear_req) |=> output_block_o)
        else $error("Output block released without clear.");
    sequence s_decel_trip;
        cause_r[trip_pkg::CAUSE_CMD_LOSS] && (loss_act == trip_pkg::ACT_DECEL) && !clear_req;
    endsequence
    chk_loss_decel: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_decel_trip |=> decel_stop_o)
        else $error("Loss trip did not request decelerating stop.");
    chk_out2_loss: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (out2_func_r == trip_pkg::OUT_CMD_LOSS && loss_qualified) |=> output2_o)
        else $error("Output two missed command loss.");
    chk_ovl_trip: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ovl_trip |=> cause_r[trip_pkg::CAUSE_OVERLOAD] && output_block_o)
        else $error("Overload did not trip.");
endmodule
`default_nettype wire

// ===== testbench/field_wiring_model.sv
// Purpose: Behavioural motor phases and terminal contacts facing the trip logic.
// Assumes: Requests come from the bench, synchronous to clk_i.
// Notes: Phases and contacts settle one clock after each request.
`timescale 1ns/10ps
`default_nettype none
module field_wiring_model (
    input wire logic clk_i,
    input wire logic [2:0] phase_req_i,
    input wire logic [4:0] contact_req_i,
    output var logic [2:0] phase_open_o = 3'h0,
    output var logic [4:0] dig_in_o = 5'h00
);
    // A winding is open or whole; a contact is closed to common or open.
    // The bench may change a tripped contact's function before it recloses the contact.
    always_ff @(posedge clk_i) begin
        phase_open_o <= phase_req_i;
        dig_in_o <= contact_req_i;
    end
endmodule
`default_nettype wire

// ===== testbench/drive_protection_trip_logic_tb_top.sv
// Purpose: Self-checking bench for the drive protection and trip logic.
// Assumes: Short tick parameters keep protection timers to a few hundred cycles.
// Notes: Flag checks pack block, decel, relay, output2 and irq into five bits.
`timescale 1ns/10ps
`default_nettype none
module drive_protection_trip_logic_tb_top;
    localparam int QT = 20;
    localparam int OT = 4;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, wb_ack_o, blk, dec, rly, out2, irq;
    logic [3:0] sel = 4'h0;
    logic [7:0] adr = 8'h00, e = 8'h00, cfg;
    logic [31:0] dat = 32'h0, q, wb_dat_o;
    logic [2:0] ph = 3'h0, phase_open;
    logic [4:0] ct_req = 5'h02, dig_in, x;
    logic [11:0] va = 12'hFFF, aux = 12'hFFF, cur = 12'hFFF, v;
    logic [7:0] cfgs [10] = '{8'h10, 8'h14, 8'h04, 8'h14, 8'h24, 8'h08, 8'h18, 8'h28, 8'h98, 8'h98};
    int seed = 16, n_mismatch = 0, n_checks = 0, n;
    always #5 clk_i = ~clk_i;
    field_wiring_model fm (.clk_i(clk_i), .phase_req_i(ph), .contact_req_i(ct_req),
        .phase_open_o(phase_open), .dig_in_o(dig_in));
    drive_protection_trip_logic #(.QUAL_TICK(QT), .OVL_TICK(OT)) dut (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .phase_open_i(phase_open), .dig_in_i(dig_in), .overload_excess_i(e),
        .voltage_analog_input_i(va), .aux_voltage_input_i(aux), .current_analog_input_i(cur),
        .output_block_o(blk), .decel_stop_o(dec), .relay_o(rly), .output2_o(out2), .irq_o(irq));
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hF;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic ct(input logic [7:0] c);
        tick(3);
        wb(1'b1, trip_pkg::OFS_CTRL, {24'h0, c});
        tick(4);
    endtask
    task automatic fl(input logic [4:0] f);
        @(negedge clk_i);
        chk({27'h0, blk, dec, rly, out2, irq}, {27'h0, f});
        @(posedge clk_i);
    endtask
    function automatic int ovl(input logic [7:0] y);
        return ((trip_pkg::OVL_BUDGET + int'(y) - 1) / int'(y)) * OT;
    endfunction
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #400000;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        fl(5'h00);
        rc(trip_pkg::OFS_CTRL, 32'h0);
        rc(trip_pkg::OFS_IN_FUNC, 32'h00418000);
        rc(trip_pkg::OFS_OUT_FUNC, 32'h00001111);
        rc(trip_pkg::OFS_QUAL_TIME, 32'h0000000A);
        rc(8'h24, 32'h0);
        $display("test reset values done");
        wb(1'b1, trip_pkg::OFS_IRQ_MASK, 32'h1);
        ph <= 3'h1 << ((32'($random(seed)) & 32'hFF) % 3);
        tick(6);
        fl(5'h00);
        ct(8'h01);
        fl(5'h11);
        ct(8'h41);
        fl(5'h11);
        ph <= 3'h0;
        ct(8'h41);
        fl(5'h01);
        rc(trip_pkg::OFS_IRQ_STAT, 32'h1);
        wb(1'b1, trip_pkg::OFS_IRQ_STAT, 32'h1);
        fl(5'h00);
        rc(trip_pkg::OFS_CTRL, 32'h1);
        ct(8'h00);
        $display("test phase loss done");
        wb(1'b1, trip_pkg::OFS_IN_FUNC, 32'h00090272);
        ct_req <= 5'h0A;
        tick(4);
        fl(5'h00);
        ct_req <= 5'h0B;
        tick(4);
        fl(5'h10);
        ct_req <= 5'h02;
        ct(8'h40);
        fl(5'h00);
        ct_req <= 5'h00;
        tick(4);
        fl(5'h10);
        ct(8'h40);
        fl(5'h10);
        wb(1'b1, trip_pkg::OFS_IN_FUNC, 32'h00090012);
        ct_req <= 5'h02;
        ct(8'h40);
        fl(5'h10);
        wb(1'b1, trip_pkg::OFS_IN_FUNC, 32'h00090272);
        ct_req <= 5'h02;
        ct(8'h40);
        fl(5'h00);
        rc(trip_pkg::OFS_IRQ_STAT, 32'h6);
        wb(1'b1, trip_pkg::OFS_IN_FUNC, 32'h0009027C);
        rc(trip_pkg::OFS_IN_FUNC, 32'h00090272);
        ct_req <= 5'h0A;
        ct(8'h02);
        fl(5'h10);
        ct_req <= 5'h02;
        ct(8'h42);
        fl(5'h00);
        $display("test external trip done");
        wb(1'b1, trip_pkg::OFS_OUT_FUNC, 32'h00001406);
        rc(trip_pkg::OFS_OUT_FUNC, 32'h00001106);
        for (int i = 0; i < 2; i++) begin
            e <= (i == 1) ? 8'h1E : (8'h80 | 8'($random(seed)));
            n = 0;
            while (rly !== 1'b1 && n < 2000) begin
                @(negedge clk_i);
                n++;
            end
            chk(32'(n >= ovl(e) - OT && n <= ovl(e) + 2 * OT), 32'h1);
            fl(5'h14);
            e <= 8'h00;
            ct(8'h40);
            fl(5'h00);
        end
        $display("test overload done");
        wb(1'b1, trip_pkg::OFS_OUT_FUNC, 32'h00000B0B);
        wb(1'b1, trip_pkg::OFS_QUAL_TIME, 32'h0);
        rc(trip_pkg::OFS_QUAL_TIME, 32'hA);
        wb(1'b1, trip_pkg::OFS_QUAL_TIME, 32'h2);
        wb(1'b1, trip_pkg::OFS_V_MIN, 32'h08000800);
        wb(1'b1, trip_pkg::OFS_I_MIN, 32'h800);
        for (int m = 0; m < 10; m++) begin
            cfg = cfgs[m];
            ct(cfg);
            v = 12'($random(seed)) & 12'h3FF;
            v = (m == 1 || m > 4) ? (v | 12'h400) : v;
            va <= (m < 8) ? v : 12'hFFF;
            aux <= (m == 8) ? v : 12'hFFF;
            cur <= (m == 9) ? v : 12'hFFF;
            tick(15);
            fl(5'h00);
            n = 0;
            while (rly !== 1'b1 && n < 100) begin
                @(negedge clk_i);
                n++;
            end
            tick(3);
            x = (m < 2) ? 5'h00 : {cfg[5:4] == 2'h1, cfg[5:4] == 2'h2, 3'b110};
            fl(x);
            va <= 12'hFFF;
            aux <= 12'hFFF;
            cur <= 12'hFFF;
            ct(cfg | 8'h40);
            fl(5'h00);
        end
        $display("test command loss done");
        wrap_up();
    end
endmodule
`default_nettype wire
